/* File: logic/cssl_cfg.svh */
// constants of the capstan speed/phase servo core
// assumes a 50 MHz system clock
`ifndef CSSL_CFG_SVH
`define CSSL_CFG_SVH
`define CSSL_CLK_HZ        50000000
`define CSSL_OSC_HZ        307200
`define CSSL_PRE_DIV       16
`define CSSL_OVS_PPS       12000
`define CSSL_OVS_CYCLES    (`CSSL_CLK_HZ / `CSSL_OVS_PPS)
`define CSSL_DIV_LOW_DEF   2
`define CSSL_DIV_HIGH_DEF  1
`define CSSL_REG_CTRL      4'h0
`define CSSL_REG_STATUS    4'h4
`define CSSL_CTRL_EXT_BIT  0
`define CSSL_CTRL_HIGH_BIT 1
`define CSSL_CTRL_FAST_BIT 2
`define CSSL_CTRL_RST      3'h0
`endif

/* File: logic/cssl_pkg.sv */
// types of the capstan speed/phase servo core
// no assumptions beyond the cfg header
`default_nettype none
package cssl_pkg;
    typedef enum logic [1:0] {
        ST_UNDER,
        ST_LOCK,
        ST_OVER
    } cssl_state_e;

    typedef struct packed {
        logic speed_up;
        logic phase;
        logic slow_down;
    } cssl_cmp_s;
endpackage
`default_nettype wire

/* File: logic/cssl_servo.sv */
// digital core of the capstan speed servo: reference chain, overspeed limiter,
// frequency/phase comparator and run-enable gating
// assumes ext_ref_i and tach_i are slow pins, sampled on mclk_i
// What this block does
// - internal reference source runs at 307.2 kHz into divider
// - first divider divides oscillator by 16 giving 19.2 kHz
// - toggle stage halves 19.2 kHz to a 9600 Hz reference
// - servo reference is internal or external 9600 Hz, as selected
// - post-divider ratio 1, 2, 4 or 8 fixed per speed at build
// - speed select routes low or high tap to limiter, blocks other
// - below limit, limiter forwards active-low pulses to comparator
// - retriggerable one-shot holds output high above about 12000 pps
// - held-high overspeed forces comparator into motor-stop state
// - tach pulses squared and inverted before comparator input
// - below speed tach drives speed-up low, reference returns it high
// - two tach pulses between references start phase toggling
// - after overshoot speed-up stays low while synchronised
// - synchronised phase output is rectangular, duty from phase difference
// - slowing: slow-down rests high, each reference forces it low
// - slowing: phase low until undershoot, then rectangular again
// - comparator result reaches filter only while run-enable high
// - run-enable also releases the motor shunt
// - both-rates halt setting: run-enable follows play request only
// - fast-only halt and low speed: run-enable always asserted
// - fast-only halt and high speed: run-enable only in play/record
// - error ranges from steady level to square wave on speed
`timescale 1ns/1ps
`default_nettype none
`include "cssl_cfg.svh"
module cssl_servo #(
    parameter int unsigned DIV_LOW    = `CSSL_DIV_LOW_DEF,
    parameter int unsigned DIV_HIGH   = `CSSL_DIV_HIGH_DEF,
    parameter int unsigned OVS_CYCLES = `CSSL_OVS_CYCLES
) (
    input  wire logic               mclk_i,
    input  wire logic               reset_n_i,
    input  wire logic [3:0]         addr_i,
    input  wire logic [31:0]        wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic [31:0]             rdata_o,
    input  wire logic               ext_ref_i,
    input  wire logic               tach_i,
    input  wire logic               play_req_i,
    output logic                    int_ref_o,
    output cssl_pkg::cssl_cmp_s     cmp_o,
    output logic                    motor_error_o,
    output logic                    error_gated_o,
    output logic                    run_enable_o,
    output logic                    motor_shunt_o,
    output logic                    overspeed_o
);
    import cssl_pkg::*;

    localparam int unsigned OW = $clog2(OVS_CYCLES + 1);

    function automatic logic tap_hit(input logic [2:0] cnt, input int unsigned ratio);
        logic [2:0] mask;
        mask = 3'(ratio - 1);
        tap_hit = ((cnt & mask) == mask);
    endfunction

    logic [2:0]  ctrl_q;
    logic [25:0] acc_q;
    logic        osc_pulse_q;
    logic [3:0]  pre_q;
    logic        int_ref_q;
    logic [1:0]  sync1_q;
    logic [1:0]  sync2_q;
    logic [1:0]  sync3_q;
    logic        ref_pulse;
    logic        tach_pulse;
    logic [2:0]  post_q;
    logic        trig;
    logic [OW-1:0] os_cnt_q;
    logic        ovs_q;
    logic        os_out_n_q;
    logic        tach_n_q;
    logic        r_pulse;
    logic        t_pulse;
    logic        r_seen_q;
    logic        t_seen_q;
    logic        two_r;
    logic        two_t;
    cssl_state_e state_q;
    cssl_state_e state_d;
    cssl_cmp_s   cmp_q;
    cssl_cmp_s   cmp_d;
    logic        err_q;
    logic        run_en;
    logic        run_en_q;
    logic        shunt_q;
    logic        gated_q;
    logic [31:0] rdata_q;
    logic        ext_sel;
    logic        speed_high;
    logic        fast_only;

    assign ext_sel    = ctrl_q[`CSSL_CTRL_EXT_BIT];
    assign speed_high = ctrl_q[`CSSL_CTRL_HIGH_BIT];
    assign fast_only  = ctrl_q[`CSSL_CTRL_FAST_BIT];

    // register port
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_q <= `CSSL_CTRL_RST;
        end else if (wr_i && addr_i == `CSSL_REG_CTRL) begin
            ctrl_q <= wdata_i[2:0];
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 32'h0;
        end else if (rd_i) begin
            unique case (addr_i)
                `CSSL_REG_CTRL:   rdata_q <= {29'h0, ctrl_q};
                `CSSL_REG_STATUS: rdata_q <= {25'h0, cmp_q, 2'(state_q), ovs_q, run_en_q};
                default:          rdata_q <= 32'h0;
            endcase
        end else begin
            rdata_q <= 32'h0;
        end
    end

    // fractional oscillator
    // phase accumulator keeps the long-term rate exact; edges jitter by one clock
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_q       <= 26'h0;
            osc_pulse_q <= 1'b0;
        end else if (acc_q + 26'(`CSSL_OSC_HZ) >= 26'(`CSSL_CLK_HZ)) begin
            acc_q       <= acc_q + 26'(`CSSL_OSC_HZ) - 26'(`CSSL_CLK_HZ);
            osc_pulse_q <= 1'b1;
        end else begin
            acc_q       <= acc_q + 26'(`CSSL_OSC_HZ);
            osc_pulse_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pre_q <= 4'h0;
        end else if (osc_pulse_q) begin
            pre_q <= (pre_q == 4'(`CSSL_PRE_DIV - 1)) ? 4'h0 : pre_q + 4'h1;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            int_ref_q <= 1'b0;
        end else if (osc_pulse_q && pre_q == 4'(`CSSL_PRE_DIV - 1)) begin
            int_ref_q <= ~int_ref_q;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            sync3_q <= 2'h0;
        end else begin
            sync1_q <= {tach_i, ext_sel ? ext_ref_i : int_ref_q};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign ref_pulse  = sync2_q[0] & ~sync3_q[0];
    assign tach_pulse = sync2_q[1] & ~sync3_q[1];

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            post_q <= 3'h0;
        end else if (ref_pulse) begin
            post_q <= post_q + 3'h1;
        end
    end

    assign trig = ref_pulse & (speed_high ? tap_hit(post_q, DIV_HIGH) : tap_hit(post_q, DIV_LOW));

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            os_cnt_q <= '0;
        end else if (trig) begin
            os_cnt_q <= OW'(OVS_CYCLES);
        end else if (os_cnt_q != '0) begin
            os_cnt_q <= os_cnt_q - OW'(1);
        end
    end

    // overspeed level
    // a trigger inside the window sets it; a quiet full window clears it
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ovs_q <= 1'b0;
        end else if (trig && os_cnt_q != '0) begin
            ovs_q <= 1'b1;
        end else if (!trig && os_cnt_q == OW'(1)) begin
            ovs_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            os_out_n_q <= 1'b1;
        end else begin
            os_out_n_q <= ~(trig && os_cnt_q == '0 && !ovs_q);
        end
    end

    // squared, inverted tach
    // extra stage keeps tach aligned with the limiter delay
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tach_n_q <= 1'b1;
        end else begin
            tach_n_q <= ~tach_pulse;
        end
    end

    assign r_pulse = ~os_out_n_q;
    assign t_pulse = ~tach_n_q;
    assign two_t   = t_pulse & t_seen_q & ~r_pulse;
    assign two_r   = r_pulse & r_seen_q & ~t_pulse;

    // pulse history since the other input last fired
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            t_seen_q <= 1'b0;
            r_seen_q <= 1'b0;
        end else if (ovs_q) begin
            t_seen_q <= 1'b0;
            r_seen_q <= 1'b0;
        end else begin
            t_seen_q <= r_pulse ? t_pulse : (t_seen_q | t_pulse);
            r_seen_q <= t_pulse ? r_pulse : (r_seen_q | r_pulse);
        end
    end

    always_comb begin
        state_d = state_q;
        if (ovs_q) begin
            state_d = ST_OVER;
        end else begin
            unique case (state_q)
                ST_UNDER: if (two_t) state_d = ST_LOCK;
                ST_LOCK: begin
                    if (two_t) begin
                        state_d = ST_OVER;
                    end else if (two_r) begin
                        state_d = ST_UNDER;
                    end
                end
                ST_OVER:  if (two_r) state_d = ST_LOCK;
                default:  state_d = ST_UNDER;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= ST_UNDER;
        end else begin
            state_q <= state_d;
        end
    end

    always_comb begin
        cmp_d = cmp_q;
        if (ovs_q) begin
            cmp_d = '{speed_up: 1'b0, phase: 1'b0, slow_down: 1'b1};
        end else begin
            unique case (state_q)
                ST_UNDER: begin
                    cmp_d.phase     = 1'b1;
                    cmp_d.slow_down = 1'b0;
                    if (t_pulse) begin
                        cmp_d.speed_up = 1'b0;
                    end
                    if (r_pulse) begin
                        cmp_d.speed_up = 1'b1;
                    end
                end
                ST_LOCK: begin
                    cmp_d.speed_up  = 1'b0;
                    cmp_d.slow_down = 1'b0;
                    if (r_pulse) begin
                        cmp_d.phase = 1'b1;
                    end else if (t_pulse) begin
                        cmp_d.phase = 1'b0;
                    end
                end
                ST_OVER: begin
                    cmp_d.speed_up = 1'b0;
                    cmp_d.phase    = 1'b0;
                    if (r_pulse) begin
                        cmp_d.slow_down = 1'b0;
                    end else if (t_pulse) begin
                        cmp_d.slow_down = 1'b1;
                    end
                end
                default: cmp_d = cmp_q;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmp_q <= '{speed_up: 1'b1, phase: 1'b1, slow_down: 1'b0};
        end else begin
            cmp_q <= cmp_d;
        end
    end

    // level at extremes, square on speed
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            err_q <= 1'b1;
        end else if (cmp_q.speed_up) begin
            err_q <= 1'b1;
        end else if (cmp_q.slow_down) begin
            err_q <= 1'b0;
        end else begin
            err_q <= cmp_q.phase;
        end
    end

    assign run_en = play_req_i | (fast_only & ~speed_high);

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_en_q <= 1'b0;
            shunt_q  <= 1'b1;
        end else begin
            run_en_q <= run_en;
            shunt_q  <= ~run_en;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gated_q <= 1'b0;
        end else begin
            gated_q <= err_q & run_en_q;
        end
    end

    assign rdata_o       = rdata_q;
    assign int_ref_o     = int_ref_q;
    assign cmp_o         = cmp_q;
    assign motor_error_o = err_q;
    assign error_gated_o = gated_q;
    assign run_enable_o  = run_en_q;
    assign motor_shunt_o = shunt_q;
    assign overspeed_o   = ovs_q;

endmodule // cssl_servo
`default_nettype wire

/* File: verif/cssl_pulse_model.sv */
// square-wave source: the capstan tachometer, or an external reference
// a shunted motor stands still, so its tach line freezes
`timescale 1ns/1ps
`default_nettype none
module cssl_pulse_model (
    input  wire logic        mclk_i,
    input  wire logic        shunt_i,
    input  wire logic [15:0] half_i,
    output logic             pulse_o
);
    logic [15:0] cnt_q = 16'h0;
    logic        lvl_q = 1'b0;
    assign pulse_o = lvl_q;
    always_ff @(posedge mclk_i) begin
        if (!shunt_i) begin
            if (cnt_q >= half_i) begin
                cnt_q <= 16'h1;
                lvl_q <= !lvl_q;
            end else begin
                cnt_q <= cnt_q + 16'h1;
            end
        end
    end
endmodule // cssl_pulse_model
`default_nettype wire

/* File: verif/cssl_servo_monitor.sv */
// port checker for the capstan servo core
// bound onto cssl_servo; one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module cssl_servo_monitor (
    input wire logic                mclk_i,
    input wire logic                reset_n_i,
    input wire logic [3:0]          addr_i,
    input wire logic [31:0]         wdata_i,
    input wire logic                wr_i,
    input wire logic                rd_i,
    input wire logic [31:0]         rdata_o,
    input wire logic                ext_ref_i,
    input wire logic                tach_i,
    input wire logic                play_req_i,
    input wire logic                int_ref_o,
    input wire cssl_pkg::cssl_cmp_s cmp_o,
    input wire logic                motor_error_o,
    input wire logic                error_gated_o,
    input wire logic                run_enable_o,
    input wire logic                motor_shunt_o,
    input wire logic                overspeed_o
);
    import cssl_pkg::*;
    logic [12:0] half_q;
    logic        iref_q;
    logic        seen_q;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // first half period after reset is partial, so it is skipped
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            half_q <= 13'h0;
            iref_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            iref_q <= int_ref_o;
            half_q <= (int_ref_o != iref_q) ? 13'h1 : half_q + 13'h1;
            seen_q <= seen_q | (int_ref_o != iref_q);
        end
    end
    AST_IREF: assert property (seen_q && int_ref_o != iref_q |-> half_q >= 13'ha2b && half_q <= 13'ha2e)
        else $error("internal reference half period off");
    AST_SHUNT: assert property (motor_shunt_o == !run_enable_o)
        else $error("shunt not inverse of run enable");
    AST_RUN: assert property ($past(play_req_i) |-> run_enable_o)
        else $error("play request did not raise run enable");
    AST_GATE: assert property (!run_enable_o [*2] |-> !error_gated_o)
        else $error("error passed while run enable low");
    AST_UP: assert property ($past(cmp_o.speed_up) |-> motor_error_o)
        else $error("motor error not high on speed up");
    AST_DN: assert property ($past(cmp_o.slow_down && !cmp_o.speed_up) |-> !motor_error_o)
        else $error("motor error not low on slow down");
    AST_PH: assert property (!$past(cmp_o.speed_up) && !$past(cmp_o.slow_down) |-> motor_error_o == $past(cmp_o.phase))
        else $error("motor error does not follow phase");
    AST_OVS: assert property (overspeed_o [*3] |-> cmp_o == 3'h1)
        else $error("overspeed did not force stop state");
    AST_UNDER: assert property (cmp_o.speed_up |-> cmp_o.phase && !cmp_o.slow_down)
        else $error("speed up with wrong phase or slow down");
    AST_SLOW: assert property (cmp_o.slow_down |-> !cmp_o.phase && !cmp_o.speed_up)
        else $error("slow down with phase or speed up high");
    AST_RD: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside its cycle");
    COV_OVS: cover property ($rose(overspeed_o));
    COV_LOCK: cover property (!cmp_o.speed_up && !cmp_o.slow_down && $rose(cmp_o.phase));
    COV_RUN: cover property ($rose(run_enable_o));
endmodule // cssl_servo_monitor
bind cssl_servo cssl_servo_monitor mon (.mclk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .ext_ref_i, .tach_i, .play_req_i, .int_ref_o, .cmp_o, .motor_error_o, .error_gated_o, .run_enable_o,
    .motor_shunt_o, .overspeed_o);
`default_nettype wire

/* File: verif/test_capstan_speed_phase_servo_logic.sv */
// self-checking bench for the capstan servo core
// drives the register port, play request and both pulse sources
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module test_capstan_speed_phase_servo_logic;
    import cssl_pkg::*;
    logic        mclk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        play_req_i = 1'b0;
    logic [15:0] ref_half = 16'h20;
    logic [15:0] tach_half = 16'hffff;
    logic [31:0] rdata_o;
    logic        ext_ref_i, tach_i, int_ref_o, motor_error_o, error_gated_o;
    logic        run_enable_o, motor_shunt_o, overspeed_o, rd_d = 1'b0;
    cssl_cmp_s   cmp_o;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] e_w;
    int          fail_count = 0;
    int          checked = 0;
    int          cyc = 0;
    int          t0;
    cssl_servo #(.DIV_LOW(2), .DIV_HIGH(1), .OVS_CYCLES(40)) dut (.mclk_i, .reset_n_i, .addr_i, .wdata_i,
        .wr_i, .rd_i, .rdata_o, .ext_ref_i, .tach_i, .play_req_i, .int_ref_o, .cmp_o, .motor_error_o,
        .error_gated_o, .run_enable_o, .motor_shunt_o, .overspeed_o);
    cssl_pulse_model tach_gen (.mclk_i, .shunt_i(motor_shunt_o), .half_i(tach_half), .pulse_o(tach_i));
    cssl_pulse_model ref_gen (.mclk_i, .shunt_i(1'b0), .half_i(ref_half), .pulse_o(ext_ref_i));
    always #10 mclk_i = !mclk_i;
    task automatic stop_test();
        if (fail_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge mclk_i);
        rd_i <= 1'b0;
    endtask
    // read data is due one cycle after the strobe
    always @(posedge mclk_i) begin
        cyc++;
        if (rd_d) begin
            e_w = exp_q.pop_front();
            `CHK("rdata", e_w, rdata_o & msk_q.pop_front())
        end
        rd_d <= rd_i;
        if (cyc == 80000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(34244));
        repeat (12) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rd(4'h4, 32'h60, 32'hffffffff);
        wr(4'h4, 32'h7);
        wr(4'h8, 32'h7);
        rd(4'h0, 32'h0, 32'hffffffff);
        rd(4'h8, 32'h0, 32'hffffffff);
        for (int i = 0; i < 8; i++) begin
            wr(4'h0, {29'h0, i[2:1], 1'b0});
            play_req_i <= i[0];
            repeat (2) @(posedge mclk_i);
            #1;
            `CHK("run_en", i[0] | (i[2] & !i[1]), run_enable_o)
            `CHK("shunt", !(i[0] | (i[2] & !i[1])), motor_shunt_o)
            `CHK("gated", i[0] | (i[2] & !i[1]), error_gated_o)
        end
        // ext reference at high speed, tach slow: motor below speed
        wr(4'h0, 32'h3);
        play_req_i <= 1'b1;
        // tach half period above the ref period leaves a quiet gap after each tach fall
        tach_half <= 16'h60 + 16'($urandom % 20);
        repeat (2000) @(posedge mclk_i);
        @(negedge tach_i);
        @(posedge ext_ref_i);
        repeat (4) @(posedge mclk_i);
        rd(4'h4, 32'h40, 32'h5c);
        tach_half <= 16'h1e;
        for (t0 = 0; t0 < 4000 && cmp_o.phase !== 1'b0; t0++) @(posedge mclk_i);
        `CHK("lock_wait", 1'b1, t0 < 4000)
        tach_half <= 16'h20;
        repeat (1000) @(posedge mclk_i);
        rd(4'h4, 32'h4, 32'h5c);
        tach_half <= 16'h12 + 16'($urandom % 4);
        repeat (1500) @(posedge mclk_i);
        rd(4'h4, 32'h8, 32'h6c);
        tach_half <= 16'h3c + 16'($urandom % 20);
        repeat (3000) @(posedge mclk_i);
        rd(4'h4, 32'h0, 32'h0c);
        // ref taps closer than the limiter window trip it
        ref_half <= 16'h10;
        repeat (300) @(posedge mclk_i);
        #1;
        `CHK("ovs", 1'b1, overspeed_o)
        `CHK("cmp_stop", 3'h1, cmp_o)
        `CHK("err_stop", 1'b0, motor_error_o)
        rd(4'h4, 32'h2, 32'h2);
        wr(4'h0, 32'h1);
        repeat (300) @(posedge mclk_i);
        #1;
        `CHK("ovs_low", 1'b0, overspeed_o)
        @(posedge int_ref_o);
        t0 = cyc;
        @(posedge int_ref_o);
        `CHK("iref_period", 1'b1, (cyc - t0) inside {[5206:5210]})
        stop_test();
    end
endmodule // test_capstan_speed_phase_servo_logic
`default_nettype wire
